/* File: cluster_led_config_status_regs_bench.sv */
module cluster_led_config_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lcs_pkg::*;
  logic sys_clk, nrst, ce, nvm_load, ramp_done, ext_pin, reg_wr, scale_act;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nvm_cfg, out2, out3c, out4c, max_ma, d, a;
  logic [12:0] out3_brt, out4_brt, b;
  logic [8:0] slope_ms;
  lcs_sense_s sense;
  lcs_fault_s fault_pins, faults;
  lcs_cfg_s cfg;
  int fail_count = 0;
  int compares = 0;
  int seed = 32'hc41fc59a;
  int ma_t[8] = '{25, 30, 50, 60, 80, 100, 120, 150};
  int ms_t[8] = '{0, 1, 2, 52, 105, 210, 315, 511};
  logic [7:0] cur_a[3] = '{8'h06, 8'h09, 8'h0c};
  logic [7:0] exp_q[$];

  lcs_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata));
  lcs_regs u_dut (.SYS_CLK(sys_clk), .NRST(nrst), .CE(ce), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RDATA(reg_rdata), .NVM_LOAD(nvm_load), .NVM_CFG(nvm_cfg), .RAMP_DONE(ramp_done),
    .EXT_CUR_CTRL_PIN(ext_pin), .SENSE_PINS(sense), .FAULT_PINS(fault_pins), .CFG(cfg), .OUT2_CURRENT(out2),
    .OUT3_CURRENT(out3c), .OUT4_CURRENT(out4c), .OUT3_BRIGHTNESS(out3_brt), .OUT4_BRIGHTNESS(out4_brt),
    .MAX_CURRENT_MA(max_ma), .SCALE_ACTIVE(scale_act), .SLOPE_TIME_MS(slope_ms), .FAULTS(faults));

  // ----
  // Checking
  // ----
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.rd(ad);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [7:0] cur_o(input int j);
    return j == 0 ? out2 : (j == 1 ? out3c : out4c);
  endfunction
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    forever begin
      @(u_host.rd_done);
      if (exp_q.size() == 0) chk_rd(u_host.last_rd, 8'hxx);
      else chk_rd(u_host.last_rd, exp_q.pop_front());
    end
  end

  // ----
  // Stimulus
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #(4000 * 50);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    nvm_load = 1'b0;
    nvm_cfg = 8'hff;
    ramp_done = 1'b0;
    ext_pin = 1'b0;
    sense = '0;
    fault_pins = '0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    idle(1);
    chk(13'(cfg), 13'h0000);
    chk(13'(max_ma), 13'h0019);
    @(posedge sys_clk);
    nvm_load <= 1'b1;
    @(posedge sys_clk);
    nvm_load <= 1'b0;
    idle(1);
    chk(13'(cfg), 13'h007f);
    rd_chk(8'h0d, 8'h7f);
    chk(13'(scale_act), 13'h0001);
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, 3'(i), 1'(i), 3'(i)};
      u_host.wr(8'h0d, d);
      idle(1);
      chk(13'(max_ma), 13'(ma_t[i]));
      chk(13'(slope_ms), 13'(ms_t[i]));
      chk(13'(cfg.smooth_ramp_enable), 13'(i % 2));
      rd_chk(8'h0d, {1'b0, d[6:0]});
    end
    @(posedge sys_clk);
    nvm_cfg <= 8'h35;
    fork
      u_host.wr(8'h0d, 8'h00);
      begin
        @(posedge sys_clk);
        nvm_load <= 1'b1;
        @(posedge sys_clk);
        nvm_load <= 1'b0;
      end
    join
    idle(1);
    chk(13'(cfg), 13'h0035);
    @(posedge sys_clk);
    ext_pin <= 1'b1;
    idle(4);
    chk(13'(scale_act), 13'h0000);
    for (int j = 0; j < 3; j++) begin
      d = 8'($random(seed));
      u_host.wr(cur_a[j], d);
      idle(1);
      chk(13'(cur_o(j)), 13'(d));
      rd_chk(cur_a[j], d);
    end
    @(posedge sys_clk);
    ce <= 1'b0;
    u_host.wr(8'h0c, ~d);
    idle(1);
    chk(13'(out4c), 13'(d));
    @(posedge sys_clk);
    ce <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      a = c ? 8'h0a : 8'h07;
      b = 13'($random(seed));
      u_host.wr(a, {3'b111, b[12:8]});
      idle(1);
      chk(c ? out4_brt : out3_brt, 13'h0000);
      rd_chk(a, {3'b000, b[12:8]});
      u_host.wr(a + 8'h01, b[7:0]);
      idle(1);
      chk(c ? out4_brt : out3_brt, b);
      u_host.wr_brt(a, 8'h00, 8'h01);
      idle(1);
      chk(c ? out4_brt : out3_brt, 13'h0001);
    end
    @(posedge sys_clk);
    sense <= 3'b101;
    ramp_done <= 1'b1;
    idle(4);
    rd_chk(8'h0e, 8'h0d);
    @(posedge sys_clk);
    sense <= 3'b010;
    ramp_done <= 1'b0;
    idle(4);
    u_host.wr(8'h0e, 8'hff);
    rd_chk(8'h0e, 8'h02);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h11, 8'h00);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      fault_pins <= lcs_fault_s'(7'h01 << i);
      idle(5);
      u_host.clear_faults();
      idle(1);
      chk(13'(faults), 13'(7'h01 << i));
      @(posedge sys_clk);
      fault_pins <= '0;
      u_host.wr(8'h0f, 8'h00);
      rd_chk(8'h0f, 8'(8'h01 << i));
      u_host.clear_faults();
      rd_chk(8'h0f, 8'h00);
    end
    test_done();
  end
endmodule

/* File: lcs_consts.svh */
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
// Behaviour
// - Upper byte first; lower write applies brightness.
// - Outputs 3/4 brightness 13 bits, high 4:0.
// - Outputs 2-4 current level plain 8-bit RW.
// - Config bits 6:4 pick 25 to 150 mA.
// - Config bit 3 selects linear or smooth transition.
// - Config bits 2:0 pick ramp time 0-511 ms.
// - Config register loaded from non-volatile storage.
// - Status bit 3 low while ramping, high done.
// - Status bit 2 high when thermistor absent.
// - Status bit 1 high on sensor low limit.
// - Status bit 0 high on sensor high limit.
// - Fault bit 6 flags input overvoltage.
// - Fault bit 5 flags input undervoltage lockout.
// - Fault bit 4 flags thermal shutdown.
// - Fault bit 3 flags converter overcurrent.
// - Fault bit 2 flags converter output overvoltage.
// - Fault bit 1 flags input switch overcurrent.
// - Fault bit 0 flags pump output too low.
// - Writing one to clear bit clears faults.

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCS_ADDR_OUT2_CUR 8'h06
`define LCS_ADDR_OUT3_HI 8'h07
`define LCS_ADDR_OUT3_LO 8'h08
`define LCS_ADDR_OUT3_CUR 8'h09
`define LCS_ADDR_OUT4_HI 8'h0a
`define LCS_ADDR_OUT4_LO 8'h0b
`define LCS_ADDR_OUT4_CUR 8'h0c
`define LCS_ADDR_CFG 8'h0d
`define LCS_ADDR_STATUS 8'h0e
`define LCS_ADDR_FAULT 8'h0f
`define LCS_ADDR_FCLR 8'h11

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LCS_HI_MSB 4
`define LCS_FCLR_BIT 0
`define LCS_CFG_MSB 6
`define LCS_SMOOTH_BIT 3
`define LCS_RSVD_BIT 7
`define LCS_ST_ABSENT_BIT 2
`define LCS_ST_LOW_BIT 1
`define LCS_ST_HIGH_BIT 0
`define LCS_CFG_RESET 7'h00
`define LCS_BYTE_RESET 8'h00
`define LCS_HI_RESET 5'h00
`define LCS_BRT_RESET 13'h0000
`define LCS_FAULT_RESET 7'h00
`define LCS_STATUS_PAD 4'h0
`define LCS_RSVD1 1'h0
`define LCS_RSVD3 3'h0

// ----------------------------------------
// Current scale table, mA
// ----------------------------------------
`define LCS_MA_0 8'h19
`define LCS_MA_1 8'h1e
`define LCS_MA_2 8'h32
`define LCS_MA_3 8'h3c
`define LCS_MA_4 8'h50
`define LCS_MA_5 8'h64
`define LCS_MA_6 8'h78
`define LCS_MA_7 8'h96

// ----------------------------------------
// Ramp time table, ms
// ----------------------------------------
`define LCS_MS_0 9'h000
`define LCS_MS_1 9'h001
`define LCS_MS_2 9'h002
`define LCS_MS_3 9'h034
`define LCS_MS_4 9'h069
`define LCS_MS_5 9'h0d2
`define LCS_MS_6 9'h13b
`define LCS_MS_7 9'h1ff
`endif

/* File: lcs_host_model.sv */
module lcs_host_model (
  input wire logic sys_clk, // Device clock
  output logic [7:0] reg_addr, // Register address
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  input wire logic [7:0] reg_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_rd;
  event rd_done;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    last_rd = 8'h00;
  end
  // ----
  // Host cycles
  // ----
  // Data lines go stale after a write so a late sample shows up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    last_rd = reg_rdata;
    -> rd_done;
  endtask
  task automatic wr_brt(input logic [7:0] hi_a, input logic [7:0] hi, input logic [7:0] lo);
    wr(hi_a, hi);
    wr(hi_a + 8'h01, lo);
  endtask
  task automatic clear_faults();
    wr(8'h11, 8'h01);
  endtask
endmodule

/* File: lcs_pkg.sv */
package lcs_pkg;
  typedef struct packed {
    logic [2:0] max_current_range_select;
    logic smooth_ramp_enable;
    logic [2:0] ramp_time_select;
  } lcs_cfg_s;

  typedef struct packed {
    logic thermistor_absent_flag;
    logic ext_sensor_low_limit_flag;
    logic ext_sensor_high_limit_flag;
  } lcs_sense_s;

  typedef struct packed {
    logic input_overvoltage_flag;
    logic input_undervoltage_flag;
    logic overtemperature_shutdown_flag;
    logic converter_overcurrent_flag;
    logic converter_overvoltage_flag;
    logic input_switch_overcurrent_flag;
    logic pump_low_output_flag;
  } lcs_fault_s;
endpackage

/* File: lcs_regs.sv */
`include "lcs_consts.svh"

module lcs_regs (
  input wire logic SYS_CLK, // 20 MHz device clock
  input wire logic NRST, // Async reset, active low
  input wire logic CE, // Clock enable, freezes state
  input wire logic [7:0] REG_ADDR, // Register address
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic REG_WR, // Write strobe, one cycle
  output logic [7:0] REG_RDATA, // Read data of REG_ADDR
  input wire logic NVM_LOAD, // Start-up config load strobe
  input wire logic [7:0] NVM_CFG, // Stored config byte
  input wire logic RAMP_DONE, // Ramp engine finished
  input wire logic EXT_CUR_CTRL_PIN, // External current control enable
  input wire lcs_pkg::lcs_sense_s SENSE_PINS, // Sensor level pins
  input wire lcs_pkg::lcs_fault_s FAULT_PINS, // Protection event pins
  output lcs_pkg::lcs_cfg_s CFG, // Configuration fields
  output logic [7:0] OUT2_CURRENT, // out2_current_level
  output logic [7:0] OUT3_CURRENT, // out3_current_level
  output logic [7:0] OUT4_CURRENT, // out4_current_level
  output logic [12:0] OUT3_BRIGHTNESS, // out3_brightness_level
  output logic [12:0] OUT4_BRIGHTNESS, // out4_brightness_level
  output logic [7:0] MAX_CURRENT_MA, // Full-scale current, mA
  output logic SCALE_ACTIVE, // Scale in force
  output logic [8:0] SLOPE_TIME_MS, // Linear ramp time, ms
  output lcs_pkg::lcs_fault_s FAULTS // Sticky fault flags
);
  import lcs_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 1 + $bits(lcs_sense_s) + $bits(lcs_fault_s);
  logic [SYNC_W-1:0] pins_sync;
  lcs_sense_s sense;
  lcs_fault_s fault_evt;
  logic ext_ctrl;

  lcs_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .ce(CE),
    .async_in({EXT_CUR_CTRL_PIN, SENSE_PINS, FAULT_PINS}),
    .sync_out(pins_sync)
  );

  assign {ext_ctrl, sense, fault_evt} = pins_sync;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic wr_ok;
  logic wr_out3_lo;
  logic wr_out4_lo;
  logic fault_clear;

  assign wr_ok = REG_WR & CE;
  assign wr_out3_lo = wr_ok && (REG_ADDR == `LCS_ADDR_OUT3_LO);
  assign wr_out4_lo = wr_ok && (REG_ADDR == `LCS_ADDR_OUT4_LO);
  assign fault_clear = wr_ok && (REG_ADDR == `LCS_ADDR_FCLR) && REG_WDATA[`LCS_FCLR_BIT];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [4:0] out3_hi, out4_hi, next_out3_hi, next_out4_hi;
  logic [7:0] next_out2_cur, next_out3_cur, next_out4_cur;
  logic [12:0] next_out3_brt, next_out4_brt;
  lcs_cfg_s next_cfg;
  lcs_fault_s next_faults;
  logic [7:0] next_max_ma;
  logic [8:0] next_slope_ms;
  logic next_scale_active;

  always_comb begin
    next_out3_hi = out3_hi;
    next_out4_hi = out4_hi;
    next_out2_cur = OUT2_CURRENT;
    next_out3_cur = OUT3_CURRENT;
    next_out4_cur = OUT4_CURRENT;
    next_out3_brt = OUT3_BRIGHTNESS;
    next_out4_brt = OUT4_BRIGHTNESS;
    next_cfg = CFG;
    if (wr_ok) begin
      unique case (REG_ADDR)
        `LCS_ADDR_OUT2_CUR: next_out2_cur = REG_WDATA;
        `LCS_ADDR_OUT3_CUR: next_out3_cur = REG_WDATA;
        `LCS_ADDR_OUT4_CUR: next_out4_cur = REG_WDATA;
        `LCS_ADDR_OUT3_HI: next_out3_hi = REG_WDATA[`LCS_HI_MSB:0];
        `LCS_ADDR_OUT4_HI: next_out4_hi = REG_WDATA[`LCS_HI_MSB:0];
        `LCS_ADDR_OUT3_LO: next_out3_brt = {out3_hi, REG_WDATA};
        `LCS_ADDR_OUT4_LO: next_out4_brt = {out4_hi, REG_WDATA};
        `LCS_ADDR_CFG: next_cfg = REG_WDATA[`LCS_CFG_MSB:0];
        default: ; // Status and fault are read-only
      endcase
    end
    // Start-up load wins over a host write in the same cycle
    if (NVM_LOAD && CE) begin
      next_cfg = NVM_CFG[`LCS_CFG_MSB:0];
    end
  end

  // Faults are sticky; a new event beats a clear in the same cycle
  always_comb begin
    next_faults = FAULTS;
    if (CE) begin
      if (fault_clear) begin
        next_faults = `LCS_FAULT_RESET;
      end
      next_faults = next_faults | fault_evt;
    end
  end

  // Decoded limits follow the config in the same edge
  always_comb begin
    unique case (next_cfg.max_current_range_select)
      3'h0: next_max_ma = `LCS_MA_0;
      3'h1: next_max_ma = `LCS_MA_1;
      3'h2: next_max_ma = `LCS_MA_2;
      3'h3: next_max_ma = `LCS_MA_3;
      3'h4: next_max_ma = `LCS_MA_4;
      3'h5: next_max_ma = `LCS_MA_5;
      3'h6: next_max_ma = `LCS_MA_6;
      3'h7: next_max_ma = `LCS_MA_7;
    endcase
    unique case (next_cfg.ramp_time_select)
      3'h0: next_slope_ms = `LCS_MS_0;
      3'h1: next_slope_ms = `LCS_MS_1;
      3'h2: next_slope_ms = `LCS_MS_2;
      3'h3: next_slope_ms = `LCS_MS_3;
      3'h4: next_slope_ms = `LCS_MS_4;
      3'h5: next_slope_ms = `LCS_MS_5;
      3'h6: next_slope_ms = `LCS_MS_6;
      3'h7: next_slope_ms = `LCS_MS_7;
    endcase
    next_scale_active = ~ext_ctrl;
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      out3_hi <= `LCS_HI_RESET;
      out4_hi <= `LCS_HI_RESET;
      OUT2_CURRENT <= `LCS_BYTE_RESET;
      OUT3_CURRENT <= `LCS_BYTE_RESET;
      OUT4_CURRENT <= `LCS_BYTE_RESET;
      OUT3_BRIGHTNESS <= `LCS_BRT_RESET;
      OUT4_BRIGHTNESS <= `LCS_BRT_RESET;
      CFG <= `LCS_CFG_RESET;
      FAULTS <= `LCS_FAULT_RESET;
      MAX_CURRENT_MA <= `LCS_MA_0;
      SLOPE_TIME_MS <= `LCS_MS_0;
      SCALE_ACTIVE <= 1'b0;
    end else if (CE) begin
      out3_hi <= next_out3_hi;
      out4_hi <= next_out4_hi;
      OUT2_CURRENT <= next_out2_cur;
      OUT3_CURRENT <= next_out3_cur;
      OUT4_CURRENT <= next_out4_cur;
      OUT3_BRIGHTNESS <= next_out3_brt;
      OUT4_BRIGHTNESS <= next_out4_brt;
      CFG <= next_cfg;
      FAULTS <= next_faults;
      MAX_CURRENT_MA <= next_max_ma;
      SLOPE_TIME_MS <= next_slope_ms;
      SCALE_ACTIVE <= next_scale_active;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    unique case (REG_ADDR)
      `LCS_ADDR_OUT2_CUR: next_rdata = OUT2_CURRENT;
      `LCS_ADDR_OUT3_HI: next_rdata = {`LCS_RSVD3, out3_hi};
      `LCS_ADDR_OUT3_LO: next_rdata = OUT3_BRIGHTNESS[7:0];
      `LCS_ADDR_OUT3_CUR: next_rdata = OUT3_CURRENT;
      `LCS_ADDR_OUT4_HI: next_rdata = {`LCS_RSVD3, out4_hi};
      `LCS_ADDR_OUT4_LO: next_rdata = OUT4_BRIGHTNESS[7:0];
      `LCS_ADDR_OUT4_CUR: next_rdata = OUT4_CURRENT;
      `LCS_ADDR_CFG: next_rdata = {`LCS_RSVD1, CFG};
      `LCS_ADDR_STATUS: next_rdata = {`LCS_STATUS_PAD, RAMP_DONE, sense};
      `LCS_ADDR_FAULT: next_rdata = {`LCS_RSVD1, FAULTS};
      default: next_rdata = `LCS_BYTE_RESET; // Clear register is write-only
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= `LCS_BYTE_RESET;
    end else if (CE) begin
      REG_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  bright_apply_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_out3_lo |=> OUT3_BRIGHTNESS == {$past(out3_hi), $past(REG_WDATA)})
    else $error("out3 brightness not applied on low write");

  bright_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_OUT4_HI) |=> $stable(OUT4_BRIGHTNESS))
    else $error("out4 brightness changed on high write");

  cur_write_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_OUT2_CUR && !(NVM_LOAD && CE)) |=> OUT2_CURRENT == $past(REG_WDATA))
    else $error("out2 current not written");

  scale_map_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CFG.max_current_range_select == 3'h7) |-> MAX_CURRENT_MA == `LCS_MA_7)
    else $error("current scale decode wrong");

  slope_map_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CFG.ramp_time_select == 3'h3) |-> SLOPE_TIME_MS == `LCS_MS_3)
    else $error("ramp time decode wrong");

  cfg_load_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (NVM_LOAD && CE) |=> CFG == $past(NVM_CFG[`LCS_CFG_MSB:0]))
    else $error("config not loaded from storage");

  ramp_read_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && REG_ADDR == `LCS_ADDR_STATUS) |=> REG_RDATA[3] == $past(RAMP_DONE))
    else $error("ramp status misread");

  fault_sticky_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.overtemperature_shutdown_flag) |=> FAULTS.overtemperature_shutdown_flag [*1] ##1
    (FAULTS.overtemperature_shutdown_flag || $past(fault_clear)))
    else $error("thermal fault not held");

  fault_clear_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (fault_clear && fault_evt == `LCS_FAULT_RESET) |=> FAULTS == `LCS_FAULT_RESET)
    else $error("faults not cleared");

  ro_write_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_FAULT && fault_evt == `LCS_FAULT_RESET) |=> $stable(FAULTS))
    else $error("fault register changed by write");

  hi_stage_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_OUT4_HI) |=> out4_hi == $past(REG_WDATA[`LCS_HI_MSB:0]))
    else $error("out4 high byte not staged");

  hi_read_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && REG_ADDR == `LCS_ADDR_OUT3_HI) |=> REG_RDATA[`LCS_RSVD_BIT:`LCS_HI_MSB + 1] == `LCS_RSVD3)
    else $error("high byte reserved bits not zero");

  cur3_write_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_OUT3_CUR) |=> OUT3_CURRENT == $past(REG_WDATA))
    else $error("out3 current not written");

  cur4_write_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_OUT4_CUR) |=> OUT4_CURRENT == $past(REG_WDATA))
    else $error("out4 current not written");

  scale_gate_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CE |=> SCALE_ACTIVE == !$past(ext_ctrl))
    else $error("scale enable does not follow control pin");

  smooth_write_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (wr_ok && REG_ADDR == `LCS_ADDR_CFG && !(NVM_LOAD && CE)) |=>
    CFG.smooth_ramp_enable == $past(REG_WDATA[`LCS_SMOOTH_BIT]))
    else $error("transition style not written");

  absent_read_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && REG_ADDR == `LCS_ADDR_STATUS) |=> REG_RDATA[`LCS_ST_ABSENT_BIT] == $past(sense.thermistor_absent_flag))
    else $error("thermistor status misread");

  low_read_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && REG_ADDR == `LCS_ADDR_STATUS) |=> REG_RDATA[`LCS_ST_LOW_BIT] == $past(sense.ext_sensor_low_limit_flag))
    else $error("low limit status misread");

  high_read_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && REG_ADDR == `LCS_ADDR_STATUS) |=> REG_RDATA[`LCS_ST_HIGH_BIT] == $past(sense.ext_sensor_high_limit_flag))
    else $error("high limit status misread");

  in_ov_set_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.input_overvoltage_flag) |=> FAULTS.input_overvoltage_flag)
    else $error("input overvoltage flag not set");

  in_uv_set_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.input_undervoltage_flag) |=> FAULTS.input_undervoltage_flag)
    else $error("input undervoltage flag not set");

  conv_oc_set_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.converter_overcurrent_flag) |=> FAULTS.converter_overcurrent_flag)
    else $error("converter overcurrent flag not set");

  conv_ov_set_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.converter_overvoltage_flag) |=> FAULTS.converter_overvoltage_flag)
    else $error("converter overvoltage flag not set");

  sw_oc_set_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.input_switch_overcurrent_flag) |=> FAULTS.input_switch_overcurrent_flag)
    else $error("input switch flag not set");

  pump_low_set_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && fault_evt.pump_low_output_flag) |=> FAULTS.pump_low_output_flag)
    else $error("pump output flag not set");

  rsvd_read_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (CE && REG_ADDR == `LCS_ADDR_FAULT) |=> REG_RDATA[`LCS_RSVD_BIT] == `LCS_RSVD1)
    else $error("fault reserved bit not zero");
endmodule

/* File: lcs_sync.sv */
module lcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Device clock
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [WIDTH-1:0] async_in, // Pins from analog side
  output logic [WIDTH-1:0] sync_out // Two-flop synchronised
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else if (ce) begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule
